// [micsb_pkg.sv]
// constants and types shared by the interrupt and configuration sideband
package micsb_pkg;

	localparam int unsigned MICSB_VEC_W   = 5;
	localparam int unsigned MICSB_TC_W    = 3;
	localparam int unsigned MICSB_MAX_MSG = 32;

	// register byte offsets
	localparam logic [4:0] MICSB_REG_MSICSR  = 5'h00;
	localparam logic [4:0] MICSB_REG_TCVCMAP = 5'h04;
	localparam logic [4:0] MICSB_REG_BUSDEV  = 5'h08;
	localparam logic [4:0] MICSB_REG_PRMCSR  = 5'h0C;
	localparam logic [4:0] MICSB_REG_DEVCSR  = 5'h10;
	localparam logic [4:0] MICSB_REG_LINKCSR = 5'h14;
	localparam logic [4:0] MICSB_REG_STATUS  = 5'h18;

	// field positions
	localparam int unsigned MICSB_MSI_EN_BIT   = 0;
	localparam int unsigned MICSB_MMC_LSB      = 1;
	localparam int unsigned MICSB_MME_LSB      = 4;
	localparam int unsigned MICSB_INTX_DIS_BIT = 10;
	localparam int unsigned MICSB_TC0_W        = 3;
	localparam int unsigned MICSB_BUS_LSB      = 5;
	localparam int unsigned MICSB_ST_INT_BIT   = 0;
	localparam int unsigned MICSB_ST_INTX_BIT  = 1;
	localparam int unsigned MICSB_ST_BUSY_BIT  = 2;

	// field values and reset values
	localparam logic [2:0]  MICSB_MMC_32      = 3'h5;
	localparam logic [2:0]  MICSB_MME_MAX     = 3'h5;
	localparam logic [2:0]  MICSB_TC_SYS      = 3'h0;
	localparam logic [2:0]  MICSB_RST_MME     = 3'h0;
	localparam logic [23:0] MICSB_RST_TCVCMAP = 24'h000000;
	localparam logic [12:0] MICSB_RST_BUSDEV  = 13'h0000;
	localparam logic [31:0] MICSB_RST_CSR     = 32'h00000000;

	typedef enum logic [1:0] {ARB_IDLE, ARB_SEND, ARB_ACK} micsb_arb_e;
	typedef enum logic [1:0] {SRC_APP, SRC_PM, SRC_SYS} micsb_src_e;

endpackage

// [micsb_msi_if.sv]
// message path between register side and msi arbiter
`timescale 1ns/100ps
`default_nettype none
interface micsb_msi_if;
	logic       msi_en;
	logic [2:0] mme;
	logic       out_valid;
	logic       out_ready;
	logic [4:0] out_vector;
	logic [2:0] out_tc;
	logic       busy;

	modport cfg (output msi_en, output mme, output out_ready,
		input out_valid, input out_vector, input out_tc, input busy);
	modport arb (input msi_en, input mme, input out_ready,
		output out_valid, output out_vector, output out_tc, output busy);
endinterface
`default_nettype wire

// [micsb_msi_arb.sv]
// msi arbiter: picks system error, power/hot-plug or application request
`timescale 1ns/100ps
`default_nettype none
module micsb_msi_arb
	import micsb_pkg::*;
#(
	parameter int unsigned MAX_MSG = MICSB_MAX_MSG
) (
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic       app_msi_req,
	input  wire logic [4:0] app_msi_num,
	input  wire logic [2:0] msi_traffic_class,
	output logic            app_msi_ack,
	input  wire logic       pm_msi_req,
	input  wire logic [4:0] pm_msi_num,
	input  wire logic       syserr_req,
	micsb_msi_if.arb        msi
);
	localparam logic [2:0] MME_LIM = 3'($clog2(MAX_MSG));

	if (MAX_MSG < 1 || MAX_MSG > MICSB_MAX_MSG || (MAX_MSG & (MAX_MSG - 1)) != 0) begin : g_chk
		$error("MAX_MSG must be a power of two from 1 to 32");
	end

	typedef struct packed {
		micsb_arb_e st;
		micsb_src_e src;
		logic       pm_pend;
		logic [4:0] pm_num;
		logic       se_pend;
		logic [4:0] vec;
		logic [2:0] tc;
	} micsb_arb_s;

	micsb_arb_s q;
	micsb_arb_s next_q;

	// mask of vectors that fit in the granted count
	function automatic logic [4:0] alloc_mask(input logic [2:0] mme);
		logic [2:0] m;
		m = (mme > MME_LIM) ? MME_LIM : mme;
		return 5'((32'd1 << m) - 32'd1);
	endfunction

	function automatic logic [4:0] fit_vec(input logic [4:0] v, input logic [2:0] mme);
		return v & alloc_mask(mme);
	endfunction

	always_comb begin
		next_q = q;
		if (pm_msi_req) begin
			next_q.pm_pend = 1'b1;
			next_q.pm_num  = pm_msi_num;
		end
		next_q.se_pend = q.se_pend | syserr_req;
		unique case (q.st)
			ARB_IDLE: begin
				if (msi.msi_en) begin
					if (q.se_pend) begin
						next_q.st      = ARB_SEND;
						next_q.src     = SRC_SYS;
						next_q.vec     = fit_vec(5'h1F, msi.mme);
						next_q.tc      = MICSB_TC_SYS;
						next_q.se_pend = syserr_req;
					end else if (q.pm_pend) begin
						next_q.st      = ARB_SEND;
						next_q.src     = SRC_PM;
						next_q.vec     = fit_vec(q.pm_num, msi.mme);
						next_q.tc      = MICSB_TC_SYS;
						next_q.pm_pend = pm_msi_req;
					end else if (app_msi_req) begin
						next_q.st  = ARB_SEND;
						next_q.src = SRC_APP;
						next_q.vec = fit_vec(app_msi_num, msi.mme);
						next_q.tc  = msi_traffic_class;
					end
				end
			end
			ARB_SEND: begin
				if (msi.out_ready) begin
					next_q.st = (q.src == SRC_APP) ? ARB_ACK : ARB_IDLE;
				end
			end
			ARB_ACK: begin
				next_q.st = ARB_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			q <= '{st: ARB_IDLE, src: SRC_APP, pm_pend: 1'b0, pm_num: 5'h00,
				se_pend: 1'b0, vec: 5'h00, tc: 3'h0};
		end else begin
			q <= next_q;
		end
	end

	assign msi.out_valid  = (q.st == ARB_SEND);
	assign msi.out_vector = q.vec;
	assign msi.out_tc     = q.tc;
	assign msi.busy       = (q.st != ARB_IDLE);
	assign app_msi_ack    = (q.st == ARB_ACK);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_ack_min_latency: assert property (app_msi_ack |-> $past(app_msi_req) && $past(app_msi_req, 2))
		else $error("msi ack came too soon after request");
	a_sys_uses_tc0: assert property (msi.out_valid && q.src != SRC_APP |-> msi.out_tc == 3'h0)
		else $error("internal msi not on traffic class 0");
	a_no_send_disabled: assert property ($rose(msi.out_valid) |-> $past(msi.msi_en))
		else $error("msi started while msi disabled");
	a_vec_in_alloc: assert property (msi.out_valid |-> (msi.out_vector & ~alloc_mask(msi.mme)) == 5'h00)
		else $error("msi vector outside granted count");
	a_syserr_top_vec: assert property (msi.out_valid && q.src == SRC_SYS |-> msi.out_vector == alloc_mask(msi.mme))
		else $error("system error not on highest vector");
	a_pm_offset_vec: assert property ($rose(msi.out_valid) && q.src == SRC_PM
		|-> msi.out_vector == fit_vec($past(q.pm_num), msi.mme))
		else $error("power event vector not its offset");
	a_ack_after_send: assert property (app_msi_ack |-> $past(msi.out_valid && msi.out_ready) ##1 !app_msi_ack)
		else $error("ack without accepted message");
	a_send_holds: assert property (msi.out_valid && !msi.out_ready |=> msi.out_valid && $stable(msi.out_vector))
		else $error("pending msi dropped or changed");

	c_app_msi: cover property (app_msi_req ##[1:8] app_msi_ack);
	c_sys_msi: cover property (msi.out_valid && q.src == SRC_SYS && msi.out_ready);
	c_pm_msi: cover property (msi.out_valid && q.src == SRC_PM && msi.out_ready);

endmodule // micsb_msi_arb
`default_nettype wire

// [micsb_top.sv]
// interrupt and configuration sideband with avalon-mm register slave
//
// What this block does
// - while legacy status is high, send INTx assert unless interrupt-disable is set, and hold status.
// - up to 32 distinct msi vectors, offset from base data.
// - msi acknowledge comes at least two cycles after the request.
// - all 32 granted: system error 31, power/hot-plug 30, application 29..0.
// - four granted: system error 3, power/hot-plug 2 or 3, application rest.
// - system error, power and hot-plug msi always go on traffic class 0.
// - 24-bit class-to-channel map, three bits per class, class 0 always zero.
// - 13-bit identity output, bus in 12..5, device in 4..0.
// - primary, device and link control/status words always driven out.
// - application raises msi request, block acknowledges once message accepted.
// - granted count shown in msi control bits 6..4 as power of two.
// - msi enable bit 0 low means no new msi is started; a message already offered still completes.
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module micsb_top
	import micsb_pkg::*;
#(
	parameter int unsigned MAX_MSG = MICSB_MAX_MSG
) (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        app_msi_req,
	input  wire logic [4:0]  app_msi_num,
	input  wire logic [2:0]  msi_traffic_class,
	output logic             app_msi_ack,
	input  wire logic        pm_msi_req,
	input  wire logic [4:0]  pm_msi_num,
	input  wire logic        syserr_req,
	output logic             msi_tx_valid,
	input  wire logic        msi_tx_ready,
	output logic [4:0]       msi_tx_vector,
	output logic [2:0]       msi_tx_tc,
	input  wire logic        app_int_sts,
	output logic             int_status,
	output logic             intx_assert_msg,
	output logic             intx_deassert_msg,
	output logic [15:0]      cfg_msicsr,
	output logic [23:0]      cfg_tcvcmap,
	output logic [12:0]      cfg_busdev,
	output logic [31:0]      cfg_prmcsr,
	output logic [31:0]      cfg_devcsr,
	output logic [31:0]      cfg_linkcsr
);
	typedef struct packed {
		logic        served;
		logic [31:0] rdata;
		logic        msi_en;
		logic [2:0]  mme;
		logic [23:0] tcvc;
		logic [12:0] busdev;
		logic [31:0] prm;
		logic [31:0] dev;
		logic [31:0] link;
		logic        int_sts;
		logic        intx_on;
		logic        assert_msg;
		logic        deassert_msg;
	} micsb_top_s;

	micsb_top_s q;
	micsb_top_s next_q;
	micsb_msi_if msi ();

	logic        wr_take;
	logic [15:0] msicsr_val;

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// msi control word: per-vector and 64-bit capability reported as absent
	assign msicsr_val = {7'h00, 1'b0, 1'b0, q.mme, MICSB_MMC_32, q.msi_en};

	assign wr_take         = avs_write && q.served;
	assign avs_waitrequest = (avs_read || avs_write) && !q.served;

	always_comb begin
		logic [31:0] wv;
		logic [31:0] rv;
		logic        intx_want;
		wv = 32'h00000000;
		rv = 32'h00000000;
		intx_want = 1'b0;
		next_q = q;
		next_q.served = (avs_read || avs_write) && !q.served;
		unique case (avs_address)
			MICSB_REG_MSICSR:  rv = {16'h0000, msicsr_val};
			MICSB_REG_TCVCMAP: rv = {8'h00, q.tcvc};
			MICSB_REG_BUSDEV:  rv = {19'h00000, q.busdev};
			MICSB_REG_PRMCSR:  rv = q.prm;
			MICSB_REG_DEVCSR:  rv = q.dev;
			MICSB_REG_LINKCSR: rv = q.link;
			MICSB_REG_STATUS:  rv = {29'h00000000, msi.busy, q.intx_on, q.int_sts};
			default:           rv = 32'h00000000;
		endcase
		if (avs_read && !q.served) begin
			next_q.rdata = rv;
		end
		if (wr_take) begin
			unique case (avs_address)
				MICSB_REG_MSICSR: begin
					wv = be_merge({16'h0000, msicsr_val}, avs_writedata, avs_byteenable);
					next_q.msi_en = wv[MICSB_MSI_EN_BIT];
					// reserved count codes are refused, old grant kept
					if (wv[MICSB_MME_LSB +: 3] <= MICSB_MME_MAX) begin
						next_q.mme = wv[MICSB_MME_LSB +: 3];
					end
				end
				MICSB_REG_TCVCMAP: begin
					wv = be_merge({8'h00, q.tcvc}, avs_writedata, avs_byteenable);
					next_q.tcvc = {wv[23:MICSB_TC0_W], 3'h0};
				end
				MICSB_REG_BUSDEV: begin
					wv = be_merge({19'h00000, q.busdev}, avs_writedata, avs_byteenable);
					next_q.busdev = wv[12:0];
				end
				MICSB_REG_PRMCSR:  next_q.prm = be_merge(q.prm, avs_writedata, avs_byteenable);
				MICSB_REG_DEVCSR:  next_q.dev = be_merge(q.dev, avs_writedata, avs_byteenable);
				MICSB_REG_LINKCSR: next_q.link = be_merge(q.link, avs_writedata, avs_byteenable);
				default: begin
				end
			endcase
		end
		// legacy interrupt: command register interrupt-disable suppresses messages
		next_q.int_sts = app_int_sts;
		intx_want = app_int_sts && !q.prm[MICSB_INTX_DIS_BIT];
		next_q.assert_msg   = intx_want && !q.intx_on;
		next_q.deassert_msg = !intx_want && q.intx_on;
		next_q.intx_on      = intx_want;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			q <= '{served: 1'b0, rdata: 32'h00000000, msi_en: 1'b0, mme: MICSB_RST_MME,
				tcvc: MICSB_RST_TCVCMAP, busdev: MICSB_RST_BUSDEV, prm: MICSB_RST_CSR,
				dev: MICSB_RST_CSR, link: MICSB_RST_CSR, int_sts: 1'b0, intx_on: 1'b0,
				assert_msg: 1'b0, deassert_msg: 1'b0};
		end else begin
			q <= next_q;
		end
	end

	assign msi.msi_en    = q.msi_en;
	assign msi.mme       = q.mme;
	assign msi.out_ready = msi_tx_ready;

	micsb_msi_arb #(
		.MAX_MSG(MAX_MSG)
	) u_arb (
		.sys_clk          (sys_clk),
		.reset            (reset),
		.app_msi_req      (app_msi_req),
		.app_msi_num      (app_msi_num),
		.msi_traffic_class(msi_traffic_class),
		.app_msi_ack      (app_msi_ack),
		.pm_msi_req       (pm_msi_req),
		.pm_msi_num       (pm_msi_num),
		.syserr_req       (syserr_req),
		.msi              (msi)
	);

	assign msi_tx_valid      = msi.out_valid;
	assign msi_tx_vector     = msi.out_vector;
	assign msi_tx_tc         = msi.out_tc;
	assign avs_readdata      = q.rdata;
	assign int_status        = q.int_sts;
	assign intx_assert_msg   = q.assert_msg;
	assign intx_deassert_msg = q.deassert_msg;
	assign cfg_msicsr        = msicsr_val;
	assign cfg_tcvcmap       = q.tcvc;
	assign cfg_busdev        = q.busdev;
	assign cfg_prmcsr        = q.prm;
	assign cfg_devcsr        = q.dev;
	assign cfg_linkcsr       = q.link;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_tc0_map_zero: assert property (cfg_tcvcmap[2:0] == 3'h0 && $stable(cfg_tcvcmap[2:0]))
		else $error("class 0 channel field not zero");
	a_busdev_write: assert property (avs_write && !avs_waitrequest && avs_address == MICSB_REG_BUSDEV
		&& avs_byteenable == 4'hF |=> cfg_busdev == $past(avs_writedata[12:0]))
		else $error("identity output did not take write");
	a_prm_track: assert property (avs_write && !avs_waitrequest && avs_address == MICSB_REG_PRMCSR
		&& avs_byteenable == 4'hF |=> cfg_prmcsr == $past(avs_writedata))
		else $error("primary word output did not follow write");
	a_intx_assert: assert property ($rose(app_int_sts) && !cfg_prmcsr[MICSB_INTX_DIS_BIT] && !intx_assert_msg
		&& !q.intx_on |=> intx_assert_msg && int_status ##1 !intx_assert_msg)
		else $error("legacy assert message missing");
	a_mme_legal: assert property (cfg_msicsr[6:4] <= 3'h5)
		else $error("reserved message count granted");

	c_reg_read: cover property (avs_read && !avs_waitrequest && avs_address == MICSB_REG_STATUS);
	c_intx_cycle: cover property (intx_assert_msg ##[1:20] intx_deassert_msg);

endmodule // micsb_top
`default_nettype wire

// [micsb_link_model.sv]
// link-side model that takes msi messages after a set stall
`timescale 1ns/100ps
`default_nettype none
module micsb_link_model (
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic       msi_tx_valid,
	input  wire logic [3:0] stall,
	output logic            msi_tx_ready
);
	logic [3:0] wait_cnt;

	// ready for one cycle only, then waits for the next message
	always_ff @(posedge sys_clk) begin
		if (reset || !msi_tx_valid || msi_tx_ready) begin
			wait_cnt     <= 4'h0;
			msi_tx_ready <= 1'b0;
		end else if (wait_cnt == stall) begin
			msi_tx_ready <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule // micsb_link_model
`default_nettype wire

// [test_msi_intx_cfg_sideband.sv]
// self-checking bench for the interrupt and configuration sideband
`timescale 1ns/100ps
`default_nettype none
module test_msi_intx_cfg_sideband;
	import micsb_pkg::*;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        app_msi_req = 1'b0;
	logic [4:0]  app_msi_num = 5'h00;
	logic [2:0]  msi_traffic_class = 3'h0;
	logic        app_msi_ack;
	logic        pm_msi_req = 1'b0;
	logic [4:0]  pm_msi_num = 5'h00;
	logic        syserr_req = 1'b0;
	logic        msi_tx_valid;
	logic        msi_tx_ready;
	logic [4:0]  msi_tx_vector;
	logic [2:0]  msi_tx_tc;
	logic        app_int_sts = 1'b0;
	logic        int_status;
	logic        intx_assert_msg;
	logic        intx_deassert_msg;
	logic [15:0] cfg_msicsr;
	logic [23:0] cfg_tcvcmap;
	logic [12:0] cfg_busdev;
	logic [31:0] cfg_prmcsr;
	logic [31:0] cfg_devcsr;
	logic [31:0] cfg_linkcsr;
	logic [3:0]  stall = 4'h0;
	int          fails = 0;
	int          compares = 0;
	int          cycles = 0;

	always #50 sys_clk = ~sys_clk;

	micsb_top i_dut (
		.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .app_msi_req(app_msi_req),
		.app_msi_num(app_msi_num), .msi_traffic_class(msi_traffic_class), .app_msi_ack(app_msi_ack),
		.pm_msi_req(pm_msi_req), .pm_msi_num(pm_msi_num), .syserr_req(syserr_req),
		.msi_tx_valid(msi_tx_valid), .msi_tx_ready(msi_tx_ready), .msi_tx_vector(msi_tx_vector),
		.msi_tx_tc(msi_tx_tc), .app_int_sts(app_int_sts), .int_status(int_status),
		.intx_assert_msg(intx_assert_msg), .intx_deassert_msg(intx_deassert_msg),
		.cfg_msicsr(cfg_msicsr), .cfg_tcvcmap(cfg_tcvcmap), .cfg_busdev(cfg_busdev),
		.cfg_prmcsr(cfg_prmcsr), .cfg_devcsr(cfg_devcsr), .cfg_linkcsr(cfg_linkcsr)
	);

	micsb_link_model i_link (
		.sys_clk(sys_clk), .reset(reset), .msi_tx_valid(msi_tx_valid), .stall(stall),
		.msi_tx_ready(msi_tx_ready)
	);

	task automatic final_report;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] addr, input logic [31:0] data, output logic [31:0] rd);
		@(posedge sys_clk);
		avs_address   <= addr;
		avs_write     <= wr;
		avs_read      <= !wr;
		avs_writedata <= data;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] addr, input logic [31:0] data);
		logic [31:0] v;
		bus(1'b1, addr, data, v);
		// registered outputs show the write one edge later
		@(posedge sys_clk);
	endtask

	task automatic reg_chk(input string name, input logic [4:0] addr, input logic [31:0] exp);
		logic [31:0] v;
		bus(1'b0, addr, 32'h0, v);
		check(name, v, exp);
	endtask

	// waits for the message handshake and checks vector and class
	task automatic msi_take(input string name, input logic [4:0] vec, input logic [2:0] tc);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (!(msi_tx_valid === 1'b1 && msi_tx_ready === 1'b1) && n < 40);
		check(name, {23'h0, n < 40, msi_tx_tc, msi_tx_vector}, {23'h0, 1'b1, tc, vec});
	endtask

	// ack expected at the first edge after the message handshake
	task automatic wait_ack(input string name);
		int k;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (app_msi_ack !== 1'b1 && k < 60);
		check(name, k, 32'h1);
		app_msi_req <= 1'b0;
		@(posedge sys_clk);
		check("ack_pulse", {31'h0, app_msi_ack}, 32'h0);
	endtask

	task automatic app_msi(input logic [4:0] num, input logic [2:0] tc);
		@(posedge sys_clk);
		app_msi_req       <= 1'b1;
		app_msi_num       <= num;
		msi_traffic_class <= tc;
		@(posedge sys_clk);
		check("ack_early", {31'h0, app_msi_ack}, 32'h0);
		msi_take("app_msi", num, tc);
		wait_ack("app_ack");
	endtask

	task automatic event_msi(input logic sys, input logic [4:0] num, input logic [4:0] vec);
		@(posedge sys_clk);
		syserr_req <= sys;
		pm_msi_req <= !sys;
		pm_msi_num <= num;
		@(posedge sys_clk);
		syserr_req <= 1'b0;
		pm_msi_req <= 1'b0;
		msi_take("event_msi", vec, MICSB_TC_SYS);
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			final_report;
		end
	end

	initial begin
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		reg_chk("msicsr_rst", MICSB_REG_MSICSR, 32'h0000000A);
		check("map_rst", {8'h00, cfg_tcvcmap}, 32'h0);
		wr(MICSB_REG_TCVCMAP, 32'hFFFFFFFF);
		check("tcvcmap", {8'h00, cfg_tcvcmap}, 32'h00FFFFF8);
		check("tc3_channel", {29'h0, cfg_tcvcmap[11:9]}, 32'h00000007);
		wr(MICSB_REG_BUSDEV, 32'h0000ABCD);
		check("busdev", {19'h0, cfg_busdev}, 32'h00000BCD);
		check("txn_id", {16'h0, cfg_busdev, 3'h0}, 32'h00005E68);
		wr(MICSB_REG_PRMCSR, 32'hC3A50001);
		wr(MICSB_REG_DEVCSR, 32'h5A5A5A5A);
		wr(MICSB_REG_LINKCSR, 32'hF00F1234);
		check("prmcsr", cfg_prmcsr, 32'hC3A50001);
		check("devcsr", cfg_devcsr, 32'h5A5A5A5A);
		check("linkcsr_out", cfg_linkcsr, 32'hF00F1234);
		reg_chk("linkcsr", MICSB_REG_LINKCSR, 32'hF00F1234);
		reg_chk("unmapped", 5'h1C, 32'h0);
		wr(MICSB_REG_STATUS, 32'hFFFFFFFF);
		reg_chk("status_ro", MICSB_REG_STATUS, 32'h0);
		// request held while msi is disabled, then released by enable
		@(posedge sys_clk);
		app_msi_req       <= 1'b1;
		app_msi_num       <= 5'h05;
		msi_traffic_class <= 3'h2;
		repeat (8) begin
			@(posedge sys_clk);
			check("msi_off", {30'h0, msi_tx_valid, app_msi_ack}, 32'h0);
		end
		wr(MICSB_REG_MSICSR, 32'h00000051);
		check("msicsr32", {16'h0, cfg_msicsr}, 32'h0000005B);
		msi_take("held_msi", 5'h05, 3'h2);
		wait_ack("held_ack");
		app_msi(5'h07, 3'h5);
		app_msi(5'h1D, 3'h7);
		stall <= 4'h5;
		event_msi(1'b1, 5'h00, 5'h1F);
		stall <= 4'h0;
		event_msi(1'b0, 5'h1E, 5'h1E);
		// four messages granted
		wr(MICSB_REG_MSICSR, 32'h00000021);
		event_msi(1'b1, 5'h00, 5'h03);
		event_msi(1'b0, 5'h02, 5'h02);
		event_msi(1'b0, 5'h03, 5'h03);
		app_msi(5'h01, 3'h3);
		wr(MICSB_REG_MSICSR, 32'h00000071);
		check("mme_rsvd", {16'h0, cfg_msicsr}, 32'h0000002B);
		// legacy interrupt status
		@(posedge sys_clk);
		app_int_sts <= 1'b1;
		repeat (2) @(posedge sys_clk);
		check("intx_on", {30'h0, int_status, intx_assert_msg}, 32'h3);
		@(posedge sys_clk);
		check("intx_pulse", {31'h0, intx_assert_msg}, 32'h0);
		reg_chk("status_int", MICSB_REG_STATUS, 32'h00000003);
		@(posedge sys_clk);
		app_int_sts <= 1'b0;
		repeat (2) @(posedge sys_clk);
		check("intx_off", {30'h0, int_status, intx_deassert_msg}, 32'h1);
		// interrupt-disable in the command word keeps status but no message
		wr(MICSB_REG_PRMCSR, 32'h00000400);
		app_int_sts <= 1'b1;
		repeat (2) @(posedge sys_clk);
		check("intx_masked", {30'h0, int_status, intx_assert_msg}, 32'h2);
		final_report;
	end
endmodule // test_msi_intx_cfg_sideband
`default_nettype wire
